// File: logic/flash_host_params.svh
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

`define CLK_PERIOD_NS        10
`define ADDR_W               21
`define DATA_W               16
// ===== command addresses and data
`define CMD_ADDR_555         21'h000555
`define CMD_ADDR_AAA         21'h000aaa
`define CMD_DATA_AA          16'h00aa
`define CMD_DATA_55          16'h0055
`define CMD_DATA_80          16'h0080
`define CMD_DATA_90          16'h0090
`define CMD_DATA_A0          16'h00a0
`define CMD_DATA_F0          16'h00f0
`define CMD_DATA_CHIP_ERASE  16'h0010
`define CMD_DATA_SECT_ERASE  16'h0030
// ===== identification layout
`define ID_MANUF_ADDR        21'h000000
`define ID_DEVICE_ADDR       21'h000001
`define ID_LOCK_ADDR         21'h000080
`define ID_LOCK_BIT          1
`define PROT_A7_BIT          7
`define PROT_WORDS           8
// ===== sector maps
`define SMALL_SECT_BITS      12
`define LARGE_SECT_BITS      15
`define SMALL_SECTS          8
`define BOOT_REGION_BASE_TOP 21'h1f8000
`define BOOT_REGION_END_BOT  21'h007fff
// ===== timing, figures as printed
`define T_CHIP_ERASE_S       400
`define T_SMALL_ERASE_MS     3000
`define T_LARGE_ERASE_MS     5000
`define T_WP_NS              35
`define T_WPH_NS             35
`define T_ACC_NS             70
`define T_DF_NS              25
`define T_RP_NS              500

`endif

// File: logic/flash_host_pkg.sv
package flash_host_pkg;
	typedef enum logic [2:0] {
		OP_READ,
		OP_PROGRAM,
		OP_CHIP_ERASE,
		OP_SECTOR_ERASE,
		OP_ID_READ,
		OP_PROT_READ,
		OP_RESET
	} op_t;

	typedef struct packed {
		op_t         op;
		logic [20:0] addr;
		logic [15:0] data;
	} host_req_t;

	typedef struct packed {
		logic [15:0] data;
		logic [6:0]  sector_index;
		logic        block_b_open;
		logic        timeout;
	} host_rsp_t;

	typedef struct packed {
		logic [20:0] addr;
		logic [15:0] dq_out;
		logic        dq_oe;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        rst_n;
	} flash_pins_t;
endpackage

// File: logic/sector_decode.sv
`timescale 1ns/10ps
`include "flash_host_params.svh"
module sector_decode import flash_host_pkg::*; #(
	parameter bit TOP_BOOT = 1'b0
) (
	input  wire logic [20:0] addr,
	output logic      [6:0]  sector_index,
	output logic             small_sector
);
	// ==========================================
	// address to sector index
	always_comb begin
		if (TOP_BOOT) begin
			if (addr >= `BOOT_REGION_BASE_TOP) begin // [RQ3]
				sector_index = 7'd63 + {4'h0, addr[14:12]};
				small_sector = 1'b1;
			end else begin
				sector_index = {1'b0, addr[20:15]};
				small_sector = 1'b0;
			end
		end else begin
			if (addr <= `BOOT_REGION_END_BOT) begin // [RQ2]
				sector_index = {4'h0, addr[14:12]};
				small_sector = 1'b1;
			end else begin
				sector_index = 7'd7 + {1'b0, addr[20:15]};
				small_sector = 1'b0;
			end
		end
	end
endmodule

// File: logic/flash_host.sv
// Operation
// RQ1: protection words 0-7 sit at A7 set, low bits word plus one, A20-A8 low; 0-3 factory A, 4-7 user B.
// RQ2: bottom boot has eight 4K-word sectors over 0-7FFF then 32K-word sectors from 08000 upward.
// RQ3: top boot has 32K-word sectors from 0 then eight 4K-word sectors 1F8000-1FFFFF.
// RQ4: in identification mode, A0 low reads the maker code and A0 high the device code, higher lines low.
// RQ5: whole-array erase finishes within 400 s and the device shows busy meanwhile.
// RQ6: a 4K-word sector erase finishes within 3.0 s and the host waits at least that long.
// RQ7: a 32K-word sector erase finishes within 5.0 s and the host waits at least that long.
// RQ8: the last erase cycle carries 10H for whole-array erase or 30H for one sector.
// RQ9: the last erase cycle uses address 555 for whole-array erase or any address inside the sector.
// RQ10: output gate stays high while write strobe and chip select are both low.
// RQ11: the device drives data on read strobes and latches on write strobes, else it floats.
// RQ12: with reset low the device ignores its controls and floats its data pins.
// RQ13: in identification mode a read at 80H shows block B lock on D1, zero locked.
// RQ14: after identification or protection reads the host issues the exit command first.
`timescale 1ns/10ps
`include "flash_host_params.svh"
module flash_host import flash_host_pkg::*; #(
	parameter bit          TOP_BOOT        = 1'b0,
	parameter longint unsigned CHIP_ERASE_CYC = 64'(`T_CHIP_ERASE_S) * 64'd1000 * 64'd100000,
	parameter int unsigned SMALL_ERASE_CYC = `T_SMALL_ERASE_MS * 100000,
	parameter int unsigned LARGE_ERASE_CYC = `T_LARGE_ERASE_MS * 100000,
	parameter int unsigned POLL_CYC        = 100
) (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        req_valid,
	input  wire host_req_t   req,
	output logic             req_ready,
	output logic             rsp_valid,
	output host_rsp_t        rsp,
	output flash_pins_t      pins,
	input  wire logic [15:0] dq_in,
	input  wire logic        busy_n_in
);
	localparam int unsigned WP_CYC  = (`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int unsigned WPH_CYC = (`T_WPH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int unsigned ACC_CYC = (`T_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1;
	localparam int unsigned DF_CYC  = (`T_DF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int unsigned RP_CYC  = (`T_RP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

	// wait counter is 36 bits: a whole-array erase at full length needs more than 32
	if (POLL_CYC < 1 || SMALL_ERASE_CYC < 1 || LARGE_ERASE_CYC < 1 || CHIP_ERASE_CYC < 1
	    || CHIP_ERASE_CYC > 64'h0000_000f_ffff_ffff) begin : g_bad_counts
		$error("flash_host: counts out of range");
	end

	typedef enum logic [3:0] {
		ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER, ST_READ, ST_FLOAT, ST_WAIT, ST_RESET, ST_DONE
	} state_t;

	// ==========================================
	// busy pin synchroniser
	logic busy_meta_q, busy_sync_q;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_meta_q <= 1'b1;
			busy_sync_q <= 1'b1;
		end else begin
			busy_meta_q <= busy_n_in;
			busy_sync_q <= busy_meta_q;
		end
	end

	// ==========================================
	// sector lookup
	logic [6:0] sect_idx;
	logic       sect_small;
	sector_decode #(.TOP_BOOT(TOP_BOOT)) u_decode (
		.addr        (req.addr),
		.sector_index(sect_idx),
		.small_sector(sect_small)
	);

	function automatic logic [20:0] prot_addr(input logic [2:0] word);
		prot_addr = 21'h0;
		prot_addr[`PROT_A7_BIT] = 1'b1;                    // [RQ1]
		prot_addr[3:0] = {1'b0, word} + 4'h1;              // [RQ1]
	endfunction

	// command word per step; last index of each request's sequence set in last_q when the request is taken, the exit command's in ST_FLOAT
	function automatic logic [36:0] seq_word(input op_t op, input logic [2:0] i,
	                                         input logic [20:0] a, input logic [15:0] d);
		logic [20:0] wa;
		logic [15:0] wd;
		wa = `CMD_ADDR_555;
		wd = `CMD_DATA_AA;
		case (i)
			3'd0: begin wa = `CMD_ADDR_555; wd = `CMD_DATA_AA; end
			3'd1: begin wa = `CMD_ADDR_AAA; wd = `CMD_DATA_55; end
			3'd2: begin
				wa = `CMD_ADDR_555;
				wd = (op == OP_PROGRAM) ? `CMD_DATA_A0 :
				     (op == OP_ID_READ || op == OP_PROT_READ) ? `CMD_DATA_90 : `CMD_DATA_80;
				if (op == OP_PROGRAM) wd = `CMD_DATA_A0;
			end
			3'd3: begin
				wa = (op == OP_PROGRAM) ? a : `CMD_ADDR_555;
				wd = (op == OP_PROGRAM) ? d : `CMD_DATA_AA;
			end
			3'd4: begin wa = `CMD_ADDR_AAA; wd = `CMD_DATA_55; end
			3'd5: begin
				wa = (op == OP_CHIP_ERASE) ? `CMD_ADDR_555 : a;                       // [RQ9]
				wd = (op == OP_CHIP_ERASE) ? `CMD_DATA_CHIP_ERASE : `CMD_DATA_SECT_ERASE; // [RQ8]
			end
			3'd6: begin wa = 21'h0; wd = `CMD_DATA_F0; end                               // [RQ14]
			default: begin wa = 21'h0; wd = 16'h0; end
		endcase
		seq_word = {wa, wd};
	endfunction

	// ==========================================
	// sequencer
	state_t      st_q, st_d;
	logic [35:0] cnt_q, cnt_d;
	logic [35:0] tmo_q, tmo_d;
	logic [2:0]  step_q, step_d, last_q, last_d;
	op_t         op_q, op_d;
	logic [20:0] addr_q, addr_d;
	logic [15:0] data_q, data_d;
	logic        exit_q, exit_d;
	flash_pins_t pins_q, pins_d;
	host_rsp_t   rsp_q, rsp_d;
	logic        rdy_q, rdy_d, vld_q, vld_d;
	logic [36:0] w;

	always_comb begin
		st_d = st_q; cnt_d = cnt_q; tmo_d = tmo_q; step_d = step_q; last_d = last_q;
		op_d = op_q; addr_d = addr_q; data_d = data_q; exit_d = exit_q;
		pins_d = pins_q; rsp_d = rsp_q; rdy_d = 1'b0; vld_d = 1'b0;
		w = seq_word(op_q, step_q, addr_q, data_q);
		case (st_q)
			ST_IDLE: begin
				rdy_d = 1'b1;
				if (req_valid && rdy_q) begin
					rdy_d = 1'b0;
					op_d = req.op; addr_d = req.addr; data_d = req.data;
					rsp_d = '0;
					rsp_d.sector_index = sect_idx;
					step_d = 3'd0; cnt_d = 36'd0;
					case (req.op)
						OP_PROGRAM: begin last_d = 3'd3; tmo_d = 36'(POLL_CYC); end
						OP_CHIP_ERASE: begin last_d = 3'd5; tmo_d = 36'(CHIP_ERASE_CYC); end  // [RQ5]
						OP_SECTOR_ERASE: begin
							last_d = 3'd5;
							tmo_d = sect_small ? 36'(SMALL_ERASE_CYC) : 36'(LARGE_ERASE_CYC); // [RQ6] [RQ7]
						end
						OP_ID_READ, OP_PROT_READ: last_d = 3'd2;
						default: last_d = 3'd0;
					endcase
					if (req.op == OP_PROT_READ) addr_d = prot_addr(req.addr[2:0]);
					if (req.op == OP_ID_READ && req.addr[7]) addr_d = `ID_LOCK_ADDR;          // [RQ13]
					else if (req.op == OP_ID_READ) addr_d = {20'h0, req.addr[0]};           // [RQ4]
					if (req.op == OP_RESET) begin
						st_d = ST_RESET; pins_d.rst_n = 1'b0; pins_d.dq_oe = 1'b0;        // [RQ12]
					end else if (req.op == OP_READ) begin
						st_d = ST_READ; pins_d.addr = req.addr;
						pins_d.ce_n = 1'b0; pins_d.we_n = 1'b1; pins_d.oe_n = 1'b0;       // [RQ11]
					end else st_d = ST_SETUP;
				end
			end
			ST_SETUP: begin
				pins_d.oe_n = 1'b1;                                                          // [RQ10]
				pins_d.addr = w[36:16]; pins_d.dq_out = w[15:0]; pins_d.dq_oe = 1'b1;
				pins_d.ce_n = 1'b0; pins_d.we_n = 1'b0; cnt_d = 36'd0; st_d = ST_STROBE;
			end
			ST_STROBE: begin
				cnt_d = cnt_q + 36'd1;
				if (cnt_q + 36'd1 >= 36'(WP_CYC)) begin
					pins_d.we_n = 1'b1; pins_d.ce_n = 1'b1; cnt_d = 36'd0; st_d = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				cnt_d = cnt_q + 36'd1;
				if (cnt_q + 36'd1 >= 36'(WPH_CYC)) begin
					pins_d.dq_oe = 1'b0; cnt_d = 36'd0;
					if (step_q != last_q) begin
						step_d = step_q + 3'd1; st_d = ST_SETUP;
					end else if (exit_q) begin
						exit_d = 1'b0; st_d = ST_DONE;
					end else if (op_q == OP_ID_READ || op_q == OP_PROT_READ) begin
						st_d = ST_READ; pins_d.addr = addr_q;
						pins_d.ce_n = 1'b0; pins_d.oe_n = 1'b0;                           // [RQ11]
					end else st_d = ST_WAIT;
				end
			end
			ST_READ: begin
				cnt_d = cnt_q + 36'd1;
				if (cnt_q + 36'd1 >= 36'(ACC_CYC)) begin
					rsp_d.data = dq_in;
					rsp_d.block_b_open = dq_in[`ID_LOCK_BIT];                                // [RQ13]
					pins_d.ce_n = 1'b1; pins_d.oe_n = 1'b1; cnt_d = 36'd0; st_d = ST_FLOAT;
				end
			end
			ST_FLOAT: begin
				cnt_d = cnt_q + 36'd1;
				if (cnt_q + 36'd1 >= 36'(DF_CYC)) begin
					cnt_d = 36'd0;
					if (op_q == OP_ID_READ || op_q == OP_PROT_READ) begin
						exit_d = 1'b1; step_d = 3'd6; last_d = 3'd6; st_d = ST_SETUP;     // [RQ14]
					end else st_d = ST_DONE;
				end
			end
			ST_WAIT: begin
				// device holds busy low for the whole operation; busy ignored for the first two cycles, then any high ends the wait
				cnt_d = cnt_q + 36'd1;
				if (cnt_q >= 36'd2 && busy_sync_q) st_d = ST_DONE;                         // [RQ5]
				else if (cnt_q + 36'd1 >= tmo_q) begin
					rsp_d.timeout = 1'b1; st_d = ST_DONE;                                    // [RQ6] [RQ7]
				end
			end
			ST_RESET: begin
				cnt_d = cnt_q + 36'd1;
				if (cnt_q + 36'd1 >= 36'(RP_CYC)) begin
					pins_d.rst_n = 1'b1; st_d = ST_DONE;
				end
			end
			ST_DONE: begin
				vld_d = 1'b1; st_d = ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= ST_IDLE; cnt_q <= 36'd0; tmo_q <= 36'd0; step_q <= 3'd0; last_q <= 3'd0;
			op_q <= OP_READ; addr_q <= 21'h0; data_q <= 16'h0; exit_q <= 1'b0;
			pins_q <= '{addr: 21'h0, dq_out: 16'h0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
			            we_n: 1'b1, rst_n: 1'b1};
			rsp_q <= '0; rdy_q <= 1'b0; vld_q <= 1'b0;
		end else begin
			st_q <= st_d; cnt_q <= cnt_d; tmo_q <= tmo_d; step_q <= step_d; last_q <= last_d;
			op_q <= op_d; addr_q <= addr_d; data_q <= data_d; exit_q <= exit_d;
			pins_q <= pins_d; rsp_q <= rsp_d; rdy_q <= rdy_d; vld_q <= vld_d;
		end
	end

	assign pins = pins_q;
	assign rsp = rsp_q;
	assign req_ready = rdy_q;
	assign rsp_valid = vld_q;
endmodule

// File: verification/flash_host_checker.sv
`timescale 1ns/10ps
module flash_host_checker import flash_host_pkg::*; (
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic        req_valid,
	input wire host_req_t   req,
	input wire logic        req_ready,
	input wire logic        rsp_valid,
	input wire host_rsp_t   rsp,
	input wire flash_pins_t pins,
	input wire logic [15:0] dq_in,
	input wire logic        busy_n_in
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// ==========
	// helpers
	logic [20:0] a_q;
	logic        take;
	assign take = req_valid && req_ready;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) a_q <= '0;
		else if (take) a_q <= req.addr;
	end
	// ==========
	// properties
	property p_gate; !pins.we_n && !pins.ce_n |-> pins.oe_n; endproperty
	a_gate: assert property (p_gate)
		else $error("output gate low in write");
	property p_chip; take && req.op == OP_CHIP_ERASE
		|-> ##[1:120] (!pins.we_n && pins.dq_out == 16'h0010 && pins.addr == 21'h000555); endproperty
	a_chip: assert property (p_chip)
		else $error("no whole erase cycle");
	property p_sect; take && req.op == OP_SECTOR_ERASE
		|-> ##[1:120] (!pins.we_n && pins.dq_out == 16'h0030 && pins.addr == a_q); endproperty
	a_sect: assert property (p_sect)
		else $error("no sector erase cycle");
	property p_prot; take && req.op == OP_PROT_READ
		|-> ##[1:120] (!pins.oe_n && !pins.ce_n && pins.addr == {13'h0, 1'b1, 3'h0, {1'b0, a_q[2:0]} + 4'h1});
	endproperty
	a_prot: assert property (p_prot)
		else $error("bad protection address");
	property p_exit; take && (req.op == OP_ID_READ || req.op == OP_PROT_READ)
		|-> ##[1:150] (!pins.we_n && !pins.ce_n && pins.dq_out[7:0] == 8'hf0); endproperty
	a_exit: assert property (p_exit)
		else $error("no exit command");
	property p_lock; take && req.op == OP_ID_READ && req.addr[7]
		|-> ##[1:120] (!pins.oe_n && pins.addr == 21'h000080); endproperty
	a_lock: assert property (p_lock)
		else $error("lock word not read");
	property p_float; !pins.oe_n |-> !pins.dq_oe; endproperty
	a_float: assert property (p_float)
		else $error("data driven during read");
endmodule
bind flash_host flash_host_checker flash_host_checker_i (.sys_clk(sys_clk), .reset_n(reset_n),
	.req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
	.pins(pins), .dq_in(dq_in), .busy_n_in(busy_n_in));

// File: verification/flash_dev_model.sv
`timescale 1ns/10ps
module flash_dev_model import flash_host_pkg::*; #(
	parameter bit          TOP_BOOT = 1'b0,
	parameter logic [15:0] MAKER    = 16'h00a5, // arbitrary value
	parameter logic [15:0] PART     = 16'h005a, // arbitrary value
	parameter int          BUSY_CYC = 20
) (
	input  wire logic        sys_clk,
	input  wire flash_pins_t pins,
	input  wire logic        hang,
	output logic [15:0]      dq_in,
	output logic             busy_n
);
	logic [15:0] mem [logic [20:0]];
	logic [20:0] a, wa, lo;
	logic [15:0] wd;
	logic [3:0]  step;
	logic        wv, idm, pgm, sm;
	int          bcnt;
	// command tracking starts known, else the first strobe leaves the step count unknown
	initial begin
		dq_in = 16'h0;
		{wv, idm, pgm, step} = '0;
	end
	assign busy_n = (bcnt == 0);
	// ==========
	// write side, commit after strobe ends
	always @(posedge sys_clk) begin
		if (!pins.rst_n) begin
			{wv, idm, pgm, step} <= '0;
			bcnt <= 0;
		end else if (!pins.ce_n && !pins.we_n && pins.oe_n) begin
			wa <= pins.addr;
			wd <= pins.dq_out;
			wv <= 1'b1;
		end else begin
			if (bcnt > 0 && !hang) bcnt <= bcnt - 1;
			if (wv) begin
				wv <= 1'b0;
				step <= step + 4'h1;
				sm = TOP_BOOT ? (wa >= 21'h1f8000) : (wa < 21'h008000);
				lo = sm ? (wa & 21'h1ff000) : (wa & 21'h1f8000);
				if (pgm) begin
					mem[wa] = wd;
					{pgm, step} <= '0;
					bcnt <= BUSY_CYC;
				end else if (wd[7:0] == 8'hf0) {idm, step} <= '0;
				else if (step == 4'h2 && wd[7:0] == 8'h90) begin
					idm <= 1'b1;
					step <= 4'h0;
				end else if (step == 4'h2 && wd[7:0] == 8'ha0) begin
					pgm <= 1'b1;
					step <= 4'h0;
				end else if (step == 4'h5) begin
					step <= 4'h0;
					bcnt <= BUSY_CYC;
					if (wd[7:0] == 8'h10 && wa == 21'h000555) mem.delete();
					if (wd[7:0] == 8'h30)
						for (int k = 0; k < (sm ? 4096 : 32768); k++) mem.delete(lo + k[20:0]);
				end
			end
		end
	end
	// ==========
	// read side; a released bus flips each cycle so stale data never matches
	always @(posedge sys_clk) begin
		a = pins.addr;
		if (pins.rst_n && !pins.ce_n && !pins.oe_n && pins.we_n) begin
			if (!idm) dq_in <= mem.exists(a) ? mem[a] : 16'hffff;
			else if (a == 21'h0) dq_in <= MAKER;
			else if (a == 21'h1) dq_in <= PART;
			else if (a == 21'h80) dq_in <= 16'h0002;
			else if (a[20:4] == 17'h8 && a[3:0] != 4'h0 && a[3:0] < 4'h9) dq_in <= 16'h00ff + a[3:0];
			else dq_in <= 16'hffff;
		end else dq_in <= ~dq_in;
	end
endmodule

// File: verification/flash_host_tb.sv
`timescale 1ns/10ps
module flash_host_tb import flash_host_pkg::*;;
	typedef struct {op_t op; logic [20:0] a; logic [15:0] d; bit chk; logic [15:0] ed; logic [6:0] es;} row_t;
	logic        sys_clk, reset_n, req_valid, req_ready, rsp_valid, hang, busy_n, top_valid, top_ready, top_done;
	host_req_t   req;
	host_rsp_t   rsp;
	flash_pins_t pins;
	logic [15:0] dq_in;
	host_rsp_t   rsp_top;
	int          n_fail, checks_done, cyc, lat;
	row_t rows [17] = '{
		'{OP_PROGRAM, 21'h000010, 16'h1234, 0, 16'h0, 7'h00}, '{OP_READ, 21'h000010, 16'h0, 1, 16'h1234, 7'h00},
		'{OP_PROGRAM, 21'h007fff, 16'h5678, 0, 16'h0, 7'h07}, '{OP_PROGRAM, 21'h008000, 16'h9abc, 0, 16'h0, 7'h08},
		'{OP_ID_READ, 21'h000000, 16'h0, 1, 16'h00a5, 7'h00}, '{OP_ID_READ, 21'h000001, 16'h0, 1, 16'h005a, 7'h00},
		'{OP_ID_READ, 21'h000080, 16'h0, 1, 16'h0002, 7'h00}, '{OP_PROT_READ, 21'h000000, 16'h0, 1, 16'h0100, 7'h00},
		'{OP_PROT_READ, 21'h000007, 16'h0, 1, 16'h0107, 7'h00}, '{OP_READ, 21'h008000, 16'h0, 1, 16'h9abc, 7'h08},
		'{OP_SECTOR_ERASE, 21'h000010, 16'h0, 0, 16'h0, 7'h00}, '{OP_READ, 21'h000010, 16'h0, 1, 16'hffff, 7'h00},
		'{OP_READ, 21'h007fff, 16'h0, 1, 16'h5678, 7'h07}, '{OP_READ, 21'h1fffff, 16'h0, 1, 16'hffff, 7'h46},
		'{OP_CHIP_ERASE, 21'h000555, 16'h0, 0, 16'h0, 7'h00}, '{OP_READ, 21'h008000, 16'h0, 1, 16'hffff, 7'h08},
		'{OP_RESET, 21'h0, 16'h0, 0, 16'h0, 7'h00}};
	logic [20:0] top_a [4] = '{21'h0, 21'h1f7fff, 21'h1f8000, 21'h1fffff};
	logic [6:0]  top_s [4] = '{7'h00, 7'h3e, 7'h3f, 7'h46};
	// ==========
	// parts; erase limits shrunk so a timeout fits the run
	flash_host #(.CHIP_ERASE_CYC(200), .SMALL_ERASE_CYC(60), .LARGE_ERASE_CYC(120), .POLL_CYC(100)) flash_host_i (
		.sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .dq_in(dq_in), .busy_n_in(busy_n));
	flash_dev_model flash_dev_model_i (.sys_clk(sys_clk), .pins(pins), .hang(hang), .dq_in(dq_in), .busy_n(busy_n));
	// top-boot map seen through a second controller; only its answers are read
	flash_host #(.TOP_BOOT(1'b1)) flash_host_top_i (
		.sys_clk(sys_clk), .reset_n(reset_n), .req_valid(top_valid), .req(req), .req_ready(top_ready),
		.rsp_valid(top_done), .rsp(rsp_top), .pins(), .dq_in(16'h0000), .busy_n_in(1'b1));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end
	// ==========
	// tasks
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic do_op(input op_t op, input logic [20:0] a, input logic [15:0] d);
		int t0, n;
		req <= '{op, a, d};
		req_valid <= 1'b1;
		n = 0;
		do begin @(posedge sys_clk); n++; end while (req_ready !== 1'b1 && n < 50);
		req_valid <= 1'b0;
		t0 = cyc;
		do begin @(posedge sys_clk); n++; end while (rsp_valid !== 1'b1 && n < 5000);
		lat = cyc - t0;
	endtask
	task automatic conclude();
		if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ==========
	// sequence
	initial begin
		{reset_n, req_valid, hang, top_valid} = '0;
		req = '0;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		foreach (rows[i]) begin
			do_op(rows[i].op, rows[i].a, rows[i].d);
			if (rows[i].chk) cmp("data", rows[i].ed, rsp.data);
			cmp("sector", {9'h0, rows[i].es}, {9'h0, rsp.sector_index});
			cmp("timeout", 16'h0, {15'h0, rsp.timeout});
		end
		do_op(OP_ID_READ, 21'h000080, 16'h0);
		cmp("open", 16'h1, {15'h0, rsp.block_b_open});
		foreach (top_a[i]) begin
			req <= '{OP_READ, top_a[i], 16'h0};
			top_valid <= 1'b1;
			do @(posedge sys_clk); while (top_ready !== 1'b1);
			top_valid <= 1'b0;
			do @(posedge sys_clk); while (top_done !== 1'b1);
			cmp("top", {9'h0, top_s[i]}, {9'h0, rsp_top.sector_index});
		end
		hang <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			do_op(OP_SECTOR_ERASE, i ? 21'h010000 : 21'h000000, 16'h0);
			cmp("timeout", 16'h1, {15'h0, rsp.timeout});
			cmp("wait", 16'h1, {15'h0, lat >= (i ? 120 : 60)});
		end
		hang <= 1'b0;
		repeat (30) @(posedge sys_clk);
		req <= '{OP_READ, 21'h000020, 16'h0};
		req_valid <= 1'b1;
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b0;
		req_valid <= 1'b0;
		@(posedge sys_clk);
		cmp("idle", 16'h1, {15'h0, pins.ce_n && pins.we_n && !pins.dq_oe && !rsp_valid});
		reset_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		do_op(OP_RESET, 21'h0, 16'h0);
		do_op(OP_READ, 21'h008000, 16'h0);
		cmp("data", 16'hffff, rsp.data);
		conclude();
	end
endmodule
